// ---- design/power_down_controller.sv ----
// Power-down controller: standby control register, sleep and standby
// entry on the halt strobe, and the wake and reset exits of each mode.
// Assumes core, interrupt controller and watchdog share this clock;
// reset and NMI pins are asynchronous and synchronised here.
//
// Behaviour
// RL1 - Control register 8 bits, resets to 1F
// RL2 - Bit 7 picks sleep or standby
// RL3 - Standby select set blocked while watchdog runs
// RL4 - Bit 6 floats ports in standby
// RL5 - Port float set blocked while watchdog runs
// RL6 - Bit 5 reads zero, writes ignored
// RL7 - Bits 4-0 read one, writes ignored
// RL8 - Sleep halts core only, clock runs
// RL9 - Standby stops clock, core and peripherals
// RL10 - Accepted interrupt ends sleep
// RL11 - Masked or disabled interrupt keeps sleeping
// RL12 - DMA address error ends sleep
// RL13 - Reset with NMI high: power-on reset
// RL14 - Reset with NMI low: manual reset
// RL15 - Matching NMI edge raises NMI, ends sleep
// RL16 - RAM contents kept in both modes
// RL17 - Standby ends on NMI or reset only
// RL18 - NMI exit waits watchdog overflow first
// RL19 - Halt strobe samples standby select
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module power_down_controller
    import power_down_pkg::*;
#(
    parameter int OSC_WAIT_SCALE = 256
)
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // Register port
    input  wire logic [27:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    // Core and interrupt controller
    input  wire logic        halt_strobe,
    input  wire logic        irq_request,
    input  wire logic [3:0]  irq_level,
    input  wire logic [3:0]  cpu_mask_level,
    input  wire logic        dma_address_error,
    input  wire logic        nmi_edge_select,
    // Watchdog
    input  wire logic        watchdog_run_enable,
    input  wire logic [2:0]  watchdog_clock_select,
    // Pins
    input  wire logic        reset_pin_n,
    input  wire logic        nmi_pin,
    // Power control outputs
    output logic             core_halt,
    output logic             clock_stop,
    output logic             watchdog_clock_only,
    output logic             peripheral_stop,
    output logic             peripheral_init,
    output logic             port_float,
    output logic             ram_retain,
    output logic             wake_irq,
    output logic             wake_dma_error,
    output logic             wake_nmi,
    output logic             power_on_reset,
    output logic             manual_reset,
    output logic             irq
);

    // ==========================================================
    // Pin synchronisers
    logic [1:0] reset_pin_sync_reg;
    logic [1:0] nmi_sync_reg;
    logic       reset_pin_last_reg;
    logic       nmi_last_reg;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            reset_pin_sync_reg <= 2'h3;
            nmi_sync_reg       <= 2'h0;
            reset_pin_last_reg <= 1'b1;
            nmi_last_reg       <= 1'b0;
        end
        else
        begin
            reset_pin_sync_reg <= {reset_pin_sync_reg[0], reset_pin_n};
            nmi_sync_reg       <= {nmi_sync_reg[0], nmi_pin};
            reset_pin_last_reg <= reset_pin_sync_reg[1];
            nmi_last_reg       <= nmi_sync_reg[1];
        end
    end

    logic reset_fall;
    logic nmi_valid_edge;
    assign reset_fall = reset_pin_last_reg & ~reset_pin_sync_reg[1];
    // Selected edge: 1 = rising, 0 = falling
    assign nmi_valid_edge = nmi_edge_select ? (~nmi_last_reg & nmi_sync_reg[1])
                                            : (nmi_last_reg & ~nmi_sync_reg[1]); // see RL15

    // ==========================================================
    // Standby control register
    logic standby_select_reg;
    logic port_float_reg;

    logic reg_hit_ctl;
    assign reg_hit_ctl = reg_write && (reg_addr == STANDBY_CONTROL_ADDR);

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            standby_select_reg <= STANDBY_CONTROL_RST[STANDBY_SELECT_BIT]; // see RL1
            port_float_reg     <= STANDBY_CONTROL_RST[PORT_FLOAT_BIT];
        end
        else if (reg_hit_ctl)
        begin
            // Clearing is always allowed; a refused set leaves the bit as it was
            if (!(reg_wdata[STANDBY_SELECT_BIT] && watchdog_run_enable))
                standby_select_reg <= reg_wdata[STANDBY_SELECT_BIT]; // see RL3
            if (!(reg_wdata[PORT_FLOAT_BIT] && watchdog_run_enable))
                port_float_reg     <= reg_wdata[PORT_FLOAT_BIT]; // see RL5
        end
    end

    logic [7:0] standby_control;
    // Bit 5 fixed zero, bits 4-0 fixed one
    assign standby_control = {standby_select_reg, port_float_reg, 1'b0,
                              RESERVED_ONES}; // see RL6, see RL7

    // ==========================================================
    // Mode machine
    mode_t      mode_reg;
    mode_t      mode_next;
    logic [12:0] settle_count_reg;
    logic       irq_accepted;
    logic [12:0] settle_load;

    // Interrupt controller gates disabled sources; priority vs. mask here
    assign irq_accepted = irq_request && (irq_level > cpu_mask_level); // see RL11
    assign settle_load  = 13'(OSC_WAIT_BASE * OSC_WAIT_SCALE)
                          << watchdog_clock_select; // see RL18

    always_comb
    begin
        mode_next = mode_reg;
        unique case (mode_reg)
            RUN:
                if (halt_strobe)
                    mode_next = standby_select_reg ? STANDBY : SLEEP; // see RL2, see RL19
            SLEEP:
                if (reset_fall)
                    mode_next = RUN; // see RL13, see RL14
                else if (irq_accepted || dma_address_error || nmi_valid_edge)
                    mode_next = RUN; // see RL10, see RL12, see RL15
            STANDBY:
                if (reset_fall)
                    mode_next = RUN; // see RL17
                else if (nmi_valid_edge)
                    mode_next = OSC_SETTLE; // see RL18
            OSC_SETTLE:
                if (reset_fall)
                    mode_next = RUN;
                else if (settle_count_reg == 13'h0000)
                    mode_next = RUN;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            mode_reg <= RUN;
        else
            mode_reg <= mode_next;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            settle_count_reg <= 13'h0000;
        else if (mode_reg == STANDBY)
            settle_count_reg <= settle_load - 13'h0001;
        else if (settle_count_reg != 13'h0000)
            settle_count_reg <= settle_count_reg - 13'h0001;
    end

    // ==========================================================
    // Power control outputs
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            core_halt           <= 1'b0;
            clock_stop          <= 1'b0;
            watchdog_clock_only <= 1'b0;
            peripheral_stop     <= 1'b0;
            peripheral_init     <= 1'b0;
            port_float          <= 1'b0;
        end
        else
        begin
            core_halt           <= (mode_next != RUN); // see RL8, see RL9
            clock_stop          <= (mode_next == STANDBY); // see RL9
            watchdog_clock_only <= (mode_next == OSC_SETTLE); // see RL18
            peripheral_stop     <= (mode_next == STANDBY)
                                   || (mode_next == OSC_SETTLE); // see RL9
            peripheral_init     <= (mode_reg == RUN) && (mode_next == STANDBY);
            port_float          <= port_float_reg && ((mode_next == STANDBY)
                                   || (mode_next == OSC_SETTLE)); // see RL4
        end
    end

    // RAM is never cleared by this block in either mode
    assign ram_retain = 1'b1; // see RL16

    // ==========================================================
    // Exit strobes
    logic asleep;
    assign asleep = (mode_reg == SLEEP);

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            wake_irq       <= 1'b0;
            wake_dma_error <= 1'b0;
            wake_nmi       <= 1'b0;
            power_on_reset <= 1'b0;
            manual_reset   <= 1'b0;
        end
        else
        begin
            wake_irq       <= asleep && !reset_fall && irq_accepted; // see RL10
            wake_dma_error <= asleep && !reset_fall && !irq_accepted
                              && dma_address_error; // see RL12
            wake_nmi       <= (asleep && !reset_fall && nmi_valid_edge)
                              || ((mode_reg == OSC_SETTLE) && !reset_fall
                                  && settle_count_reg == 13'h0000); // see RL15, see RL18
            power_on_reset <= reset_fall && (mode_reg != RUN)
                              && nmi_sync_reg[1]; // see RL13
            manual_reset   <= reset_fall && (mode_reg != RUN)
                              && !nmi_sync_reg[1]; // see RL14
        end
    end

    // ==========================================================
    // Interrupt status and mask
    logic [EVENT_COUNT-1:0] irq_status_reg;
    logic [EVENT_COUNT-1:0] irq_mask_reg;
    logic [EVENT_COUNT-1:0] events;

    assign events[EV_SLEEP_ENTER]   = (mode_reg == RUN) && (mode_next == SLEEP);
    assign events[EV_STANDBY_ENTER] = (mode_reg == RUN) && (mode_next == STANDBY);
    assign events[EV_WAKE]          = (mode_reg != RUN) && (mode_next == RUN)
                                      && !reset_fall;
    assign events[EV_RESET_EXIT]    = (mode_reg != RUN) && reset_fall;

    genvar i;
    generate
        for (i = 0; i < EVENT_COUNT; i++)
        begin : gen_status
            always_ff @(posedge clock)
            begin
                if (reset)
                    irq_status_reg[i] <= IRQ_RST[i];
                else if (events[i])
                    irq_status_reg[i] <= 1'b1;
                else if (reg_write && reg_addr == IRQ_STATUS_ADDR && reg_wdata[i])
                    irq_status_reg[i] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (reset)
            irq_mask_reg <= IRQ_RST;
        else if (reg_write && reg_addr == IRQ_MASK_ADDR)
            irq_mask_reg <= reg_wdata[EVENT_COUNT-1:0];
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ==========================================================
    // Read path, data one cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (reg_read)
        begin
            unique case (reg_addr)
                STANDBY_CONTROL_ADDR: reg_rdata <= standby_control;
                IRQ_STATUS_ADDR:      reg_rdata <= {4'h0, irq_status_reg};
                IRQ_MASK_ADDR:        reg_rdata <= {4'h0, irq_mask_reg};
                MODE_STATUS_ADDR:     reg_rdata <= {6'h00, mode_reg};
                default:              reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

endmodule : power_down_controller

`default_nettype wire

// ---- design/power_down_pkg.sv ----
// Package: register map, field positions, reset values and states
// of the power-down controller.
// Assumes an 8-bit register port and a single 250 MHz clock.
package power_down_pkg;

    // ==========================================================
    // Register map
    localparam logic [27:0] STANDBY_CONTROL_ADDR = 28'h5FFFFBC;
    localparam logic [27:0] IRQ_STATUS_ADDR      = 28'h5FFFFC0;
    localparam logic [27:0] IRQ_MASK_ADDR        = 28'h5FFFFC4;
    localparam logic [27:0] MODE_STATUS_ADDR     = 28'h5FFFFC8;

    // ==========================================================
    // Standby control fields
    localparam int          STANDBY_SELECT_BIT  = 7;
    localparam int          PORT_FLOAT_BIT      = 6;
    localparam int          RESERVED_ZERO_BIT   = 5;
    localparam logic [7:0]  STANDBY_CONTROL_RST = 8'h1F;
    localparam logic [4:0]  RESERVED_ONES       = 5'h1F;

    // ==========================================================
    // Event status bits
    localparam int          EV_SLEEP_ENTER   = 0;
    localparam int          EV_STANDBY_ENTER = 1;
    localparam int          EV_WAKE          = 2;
    localparam int          EV_RESET_EXIT    = 3;
    localparam int          EVENT_COUNT      = 4;
    localparam logic [3:0]  IRQ_RST          = 4'h0;

    // ==========================================================
    // Watchdog overflow base interval; the controller scales it by OSC_WAIT_SCALE and shifts it by the clock-select code
    localparam int          OSC_WAIT_BASE    = 2;

    typedef enum logic [1:0] {
        RUN,
        SLEEP,
        STANDBY,
        OSC_SETTLE
    } mode_t;

endpackage : power_down_pkg

// ---- verification/core_model.sv ----
// Partner: core halt strobe and pending interrupt request.
// Assumes bench commands are set just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module core_model
(
    // Clock, reset and commands
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic halt_go,
    input  wire logic irq_want,
    // Controller side
    input  wire logic wake_irq,
    output logic      halt_strobe,
    output logic      irq_request
);
    always_ff @(posedge clock)
    begin
        halt_strobe <= !reset && halt_go && !halt_strobe;
    end
    // Wake acts as the acknowledge, so the request drops one cycle after it
    always_ff @(posedge clock)
    begin
        irq_request <= !reset && irq_want && !wake_irq;
    end
endmodule : core_model
`default_nettype wire

// ---- verification/power_down_controller_tb.sv ----
// Testbench: register port, sleep and standby entry and their exits.
// Assumes core_model as partner and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module power_down_controller_tb;
    import power_down_pkg::*;
    // ==========================================================
    // Signals
    logic        clock = 0, reset = 1, wr_en = 0, rd_en = 0, halt_go = 0, irq_want = 0;
    logic        dma = 0, wd_run = 0, rst_n = 1, nmi = 0;
    logic [27:0] addr = '0;
    logic [7:0]  wdata = '0, rdata;
    logic [3:0]  level = 4'h0;
    logic        strobe, irq_req, halt, cstop, wd_only, pstop, pinit, pfloat, ram, irq;
    logic        w_irq, w_dma, w_nmi, por, man;
    int          mismatches = 0, compares = 0;
    wire logic [5:0] ev = {man, por, w_nmi, w_dma, w_irq, wd_only};
    always #2 clock = ~clock;
    core_model u_core (.clock(clock), .reset(reset), .halt_go(halt_go), .irq_want(irq_want),
        .wake_irq(w_irq), .halt_strobe(strobe), .irq_request(irq_req));
    power_down_controller #(.OSC_WAIT_SCALE(1)) dut (.clock(clock), .reset(reset),
        .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_en), .reg_read(rd_en),
        .reg_rdata(rdata), .halt_strobe(strobe), .irq_request(irq_req), .irq_level(level),
        .cpu_mask_level(4'h3), .dma_address_error(dma), .nmi_edge_select(1'b1),
        .watchdog_run_enable(wd_run), .watchdog_clock_select(3'h1), .reset_pin_n(rst_n),
        .nmi_pin(nmi), .core_halt(halt), .clock_stop(cstop), .watchdog_clock_only(wd_only),
        .peripheral_stop(pstop), .peripheral_init(pinit), .port_float(pfloat),
        .ram_retain(ram), .wake_irq(w_irq), .wake_dma_error(w_dma), .wake_nmi(w_nmi),
        .power_on_reset(por), .manual_reset(man), .irq(irq));
    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [27:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [27:0] a, input logic [7:0] e);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 chk("reg_rdata", e, rdata);
    endtask : rd
    // Bounded watch of one event bit; stops at the first sighting
    task automatic wt(input string what, input int b, input int n, input logic e);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < n && !hit; i++)
        begin
            @(posedge clock);
            #1 hit = (ev[b] === 1'b1);
        end
        chk(what, 8'(e), 8'(hit));
    endtask : wt
    task automatic sleep_now;
        @(posedge clock);
        halt_go <= 1'b1;
        @(posedge clock);
        halt_go <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk("core_halt", 8'h01, 8'(halt));
    endtask : sleep_now
    // ==========================================================
    // Scenarios
    task automatic t_regs;
        rd(STANDBY_CONTROL_ADDR, STANDBY_CONTROL_RST);
        rd(28'h5FFFFCC, 8'h00);
        wd_run <= 1'b1;
        wr(STANDBY_CONTROL_ADDR, 8'hC0);
        rd(STANDBY_CONTROL_ADDR, 8'h1F);
        wd_run <= 1'b0;
        wr(STANDBY_CONTROL_ADDR, 8'hC0);
        rd(STANDBY_CONTROL_ADDR, 8'hDF);
        wr(STANDBY_CONTROL_ADDR, 8'h00);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_sleep;
        wr(IRQ_STATUS_ADDR, 8'h0F);
        sleep_now;
        chk("clock_stop", 8'h00, 8'(cstop | pstop));
        level    <= 4'h3;
        irq_want <= 1'b1;
        wt("wake_irq", 1, 20, 1'b0);
        level <= 4'h4;
        wt("wake_irq", 1, 20, 1'b1);
        irq_want <= 1'b0;
        chk("core_halt", 8'h00, 8'(halt));
        chk("irq", 8'h00, 8'(irq));
        wr(IRQ_MASK_ADDR, 8'h01);
        #1 chk("irq", 8'h01, 8'(irq));
        rd(IRQ_STATUS_ADDR, 8'h05);
        wr(IRQ_STATUS_ADDR, 8'h01);
        #1 chk("irq", 8'h00, 8'(irq));
        sleep_now;
        dma <= 1'b1;
        wt("wake_dma_error", 2, 20, 1'b1);
        dma <= 1'b0;
        $display("t_sleep done");
    endtask : t_sleep
    task automatic t_standby;
        wr(STANDBY_CONTROL_ADDR, 8'hC0);
        sleep_now;
        chk("standby", 8'h0F, {4'h0, cstop, pstop, pfloat, ram});
        irq_want <= 1'b1;
        dma      <= 1'b1;
        wt("wake_irq", 1, 20, 1'b0);
        irq_want <= 1'b0;
        dma      <= 1'b0;
        nmi      <= 1'b1;
        wt("watchdog_clock_only", 0, 20, 1'b1);
        wt("wake_nmi", 3, 200, 1'b1);
        wr(STANDBY_CONTROL_ADDR, 8'h00);
        $display("t_standby done");
    endtask : t_standby
    // NMI is already high here, so no NMI edge muddies the reset kind
    task automatic t_reset;
        sleep_now;
        rst_n <= 1'b0;
        wt("power_on_reset", 4, 20, 1'b1);
        rst_n <= 1'b1;
        nmi   <= 1'b0;
        repeat (6) @(posedge clock);
        sleep_now;
        rst_n <= 1'b0;
        wt("manual_reset", 5, 20, 1'b1);
        rst_n <= 1'b1;
        $display("t_reset done");
    endtask : t_reset
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        t_regs;
        t_sleep;
        t_standby;
        t_reset;
        summarize;
    end
    initial
    begin
        #40000;
        mismatches++;
        summarize;
    end
endmodule : power_down_controller_tb
`default_nettype wire

// ---- verification/power_down_props.sv ----
// Checker: port timing of the power-down controller.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module power_down_props
#(
    parameter int OSC_WAIT_SCALE = 256
)
(
    // Watched ports
    input wire logic       clock,
    input wire logic       reset,
    input wire logic       halt_strobe,
    input wire logic       irq_request,
    input wire logic [3:0] irq_level,
    input wire logic [3:0] cpu_mask_level,
    input wire logic       dma_address_error,
    input wire logic       core_halt,
    input wire logic       clock_stop,
    input wire logic       watchdog_clock_only,
    input wire logic       peripheral_init,
    input wire logic       peripheral_stop,
    input wire logic       port_float,
    input wire logic       ram_retain,
    input wire logic       wake_irq,
    input wire logic       wake_dma_error,
    input wire logic       wake_nmi,
    input wire logic       power_on_reset,
    input wire logic       manual_reset
);
    // ==========================================================
    // Properties
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    sequence s_sleeping;
        core_halt && !peripheral_stop;
    endsequence
    sequence s_irq_ok;
        irq_request && irq_level > cpu_mask_level;
    endsequence
    a_halt_enters: assert property (halt_strobe && !core_halt |=> core_halt)
        else $error("halt strobe did not halt the core");
    a_standby_stops: assert property (clock_stop |-> core_halt && peripheral_stop)
        else $error("standby without core and peripheral stop");
    a_irq_wakes: assert property (s_sleeping ##0 s_irq_ok
        |=> wake_irq | power_on_reset | manual_reset)
        else $error("accepted interrupt did not end sleep");
    a_wake_cause: assert property (wake_irq |-> $past(irq_request) && $past(irq_level) > $past(cpu_mask_level))
        else $error("wake without an accepted interrupt");
    a_dma_wakes: assert property (s_sleeping ##0 (dma_address_error && !irq_request)
        |=> wake_dma_error || power_on_reset || manual_reset)
        else $error("address error did not end sleep");
    a_standby_holds: assert property (clock_stop |=> !wake_irq && !wake_dma_error)
        else $error("standby left by a disallowed cause");
    a_settle_first: assert property (wake_nmi && $past(peripheral_stop) |-> $past(watchdog_clock_only))
        else $error("standby exit skipped the settle time");
    a_float_standby: assert property (port_float |-> peripheral_stop)
        else $error("ports floated outside standby");
    a_ram_kept: assert property (ram_retain)
        else $error("memory retention dropped");
    a_init_entry: assert property (peripheral_init |-> clock_stop && $past(!core_halt))
        else $error("peripheral init outside standby entry");
endmodule : power_down_props
bind power_down_controller power_down_props #(.OSC_WAIT_SCALE(OSC_WAIT_SCALE)) u_props (
    .clock(clock), .reset(reset), .halt_strobe(halt_strobe), .irq_request(irq_request),
    .irq_level(irq_level), .cpu_mask_level(cpu_mask_level),
    .dma_address_error(dma_address_error), .core_halt(core_halt), .clock_stop(clock_stop),
    .watchdog_clock_only(watchdog_clock_only), .peripheral_init(peripheral_init),
    .peripheral_stop(peripheral_stop),
    .port_float(port_float), .ram_retain(ram_retain), .wake_irq(wake_irq),
    .wake_dma_error(wake_dma_error), .wake_nmi(wake_nmi),
    .power_on_reset(power_on_reset), .manual_reset(manual_reset));
`default_nettype wire
